// *** verilog/flash_guard_params.svh ***
// Purpose: Offsets, codes, layout and timing of the flash guard
// Assumes: 25 MHz system clock
// Notes:   Included by the guard module and the bench
`ifndef FLASH_GUARD_PARAMS_SVH
`define FLASH_GUARD_PARAMS_SVH
// APB register offsets
`define OFF_CONTROL      12'h000
`define OFF_KEY          12'h004
`define OFF_STATUS       12'h008
// Control and status fields
`define CTL_WRITE_BIT    0
`define CTL_ERASE_BIT    1
`define STS_BUSY_BIT     0
`define STS_DEAD_BIT     1
`define STS_KEY_LSB      2
`define STS_FLAG_BIT     4
`define STS_LOCK_LSB     8
// Unlock codes
`define KEY_FIRST        8'hA5
`define KEY_SECOND       8'hF1
// Array layout
`define LOCK_ADDR        14'h3DFF
`define LOCK_PAGE        5'h1E
`define RSVD_PAGE        5'h1F
`define LAST_ADDR        14'h3FFF
`define ERASED_BYTE      8'hFF
`define LOCK_RESET       8'hFF
// Timing
`define CLK_MHZ          25
`define PROG_TIME_US     40
`define ERASE_TIME_US    20000
`define PROG_CYCLES      (`PROG_TIME_US * `CLK_MHZ)
`define ERASE_CYCLES     (`ERASE_TIME_US * `CLK_MHZ)
`endif

// *** verilog/flash_guard_pkg.sv ***
// Purpose: Types shared by the flash guard
// Assumes: Nothing
// Notes:   Constants live in flash_guard_params.svh
package flash_guard_pkg;
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_IDLE   = 2'b01,
    ST_PROG   = 2'b10,
    ST_ERASE  = 2'b11
  } op_state_t;
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF   = 2'b01,
    KEY_OPEN   = 2'b10
  } key_state_t;
  typedef enum logic [1:0] {
    DBG_READ   = 2'b00,
    DBG_WRITE  = 2'b01,
    DBG_ERASE  = 2'b10,
    DBG_DEVICE = 2'b11
  } dbg_op_t;
endpackage

// *** verilog/flash_program_erase_guard.sv ***
// Purpose: Program flash array with unlock, page lock and erase guard
// Assumes: CPU and debug port logic run on clk; APB register access
// Notes:   cpu_stall holds the core during timed operations
//
// Overview of operation
// - Unlock needs first code then second code
// - Wrong or misordered code kills writes
// - Operation before unlock kills writes
// - Every firmware operation relocks the key
// - Programming only clears bits
// - Erase sets whole 512-byte page
// - Write enable redirects data writes
// - Write enable cleared only by software or reset
// - Erase enable plus write erases page
// - Hardware times every operation
// - CPU stalled during operations
// - Data reads always go to RAM
// - Lock byte complement locks low pages
// - Lock page locked unless byte ones
// - Firmware violation forces error reset
// - Debug violations refused without reset
// - Locked code may touch locked pages
// - Firmware never erases lock page
// - Only debug device erase clears lock
// - New lock byte applies after reset
// - Reserved area refused to all but debug device erase

`timescale 1ns/100ps
`default_nettype none
`include "flash_guard_params.svh"

module flash_program_erase_guard #(
  parameter int unsigned ERASE_WAIT = `ERASE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        por_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xwr_req,
  input  wire logic [15:0] xwr_addr,
  input  wire logic [7:0]  xwr_data,
  input  wire logic        xrd_req,
  output logic             ram_wr_en,
  output logic             ram_rd_en,
  input  wire logic [15:0] fetch_pc,
  input  wire logic        code_req,
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_data,
  output logic             code_valid,
  input  wire logic        dbg_req,
  input  wire logic [1:0]  dbg_op,
  input  wire logic [15:0] dbg_addr,
  input  wire logic [7:0]  dbg_wdata,
  output logic      [7:0]  dbg_rdata,
  output logic             dbg_ack,
  output logic             dbg_refused,
  output logic             cpu_stall,
  output logic             flash_error_reset,
  output logic             flash_error_reset_flag
);

  localparam int unsigned PROG_WAIT = `PROG_CYCLES;

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [7:0] flash_mem [0:16383];

  flash_guard_pkg::op_state_t  op_state;
  flash_guard_pkg::key_state_t key_state;
  logic        key_dead;
  logic        store_write_enable;
  logic        store_erase_enable;
  logic [7:0]  lock_byte;
  logic [19:0] op_timer;
  logic [13:0] erase_ptr;
  logic [13:0] erase_end;
  logic        erase_done;

  // ----------------------------------------
  // Page decode
  // ----------------------------------------
  function automatic logic page_locked(
    input logic [4:0] page,
    input logic [7:0] lbyte
  );
    logic [7:0] n;
    n = ~lbyte;
    page_locked = ({3'h0, page} < n) ||
      ((page == `LOCK_PAGE) && (n != 8'h00));
  endfunction

  function automatic logic page_reserved(input logic [15:0] a);
    page_reserved = (a[13:9] == `RSVD_PAGE) ||
      (a[15:14] != 2'h0);
  endfunction

  logic fw_locked;
  logic xw_flash;
  logic xw_lock;
  logic xw_bad;
  logic xw_go;
  logic cr_take;
  logic cr_bad;
  logic db_take;
  logic db_bad;
  logic lock_written;

  always_comb begin
    fw_locked = page_locked(fetch_pc[13:9], lock_byte);
    xw_lock = page_locked(xwr_addr[13:9], lock_byte);
    lock_written = (flash_mem[`LOCK_ADDR] != `ERASED_BYTE);
    xw_flash = xwr_req && store_write_enable &&
      (op_state == flash_guard_pkg::ST_IDLE);
    xw_bad = page_reserved(xwr_addr) ||
      (xw_lock && !fw_locked) ||
      (store_erase_enable &&
       (xwr_addr[13:9] == `LOCK_PAGE)) ||
      (!store_erase_enable && lock_written &&
       (xwr_addr[13:0] == `LOCK_ADDR));
    xw_go = xw_flash && !xw_bad && !key_dead &&
      (key_state == flash_guard_pkg::KEY_OPEN);
    cr_take = code_req && !xw_flash &&
      (op_state == flash_guard_pkg::ST_IDLE);
    cr_bad = page_reserved(code_addr) ||
      (page_locked(code_addr[13:9], lock_byte) && !fw_locked);
    db_take = dbg_req && !xw_flash && !code_req &&
      (op_state == flash_guard_pkg::ST_IDLE);
    db_bad = (dbg_op != flash_guard_pkg::DBG_DEVICE) &&
      (page_reserved(dbg_addr) ||
       page_locked(dbg_addr[13:9], lock_byte));
  end

  // ----------------------------------------
  // CPU side steering
  // ----------------------------------------
  assign ram_wr_en = xwr_req && !store_write_enable;
  assign ram_rd_en = xrd_req;
  assign cpu_stall = (op_state != flash_guard_pkg::ST_IDLE);

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  logic start_prog;
  logic start_erase;
  logic [13:0] start_base;
  logic [13:0] start_end;

  always_comb begin
    start_prog = 1'b0;
    start_erase = 1'b0;
    start_base = {xwr_addr[13:9], 9'h000};
    start_end = {xwr_addr[13:9], 9'h1FF};
    if (xw_go) begin
      start_prog = !store_erase_enable;
      start_erase = store_erase_enable;
    end else if (db_take && !db_bad) begin
      start_base = {dbg_addr[13:9], 9'h000};
      start_end = {dbg_addr[13:9], 9'h1FF};
      if (dbg_op == flash_guard_pkg::DBG_WRITE) begin
        start_prog = 1'b1;
      end
      if (dbg_op == flash_guard_pkg::DBG_ERASE) begin
        start_erase = 1'b1;
      end
      if (dbg_op == flash_guard_pkg::DBG_DEVICE) begin
        start_erase = 1'b1;
        start_base = 14'h0000;
        start_end = `LAST_ADDR;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_state <= flash_guard_pkg::ST_SAMPLE;
      op_timer <= 20'h00000;
      erase_ptr <= 14'h0000;
      erase_end <= 14'h0000;
      erase_done <= 1'b0;
    end else begin
      case (op_state)
        flash_guard_pkg::ST_SAMPLE: begin
          op_state <= flash_guard_pkg::ST_IDLE;
        end
        flash_guard_pkg::ST_IDLE: begin
          if (start_prog) begin
            op_state <= flash_guard_pkg::ST_PROG;
            op_timer <= 20'(PROG_WAIT - 1);
          end else if (start_erase) begin
            op_state <= flash_guard_pkg::ST_ERASE;
            op_timer <= 20'(ERASE_WAIT - 1);
            erase_ptr <= start_base;
            erase_end <= start_end;
            erase_done <= 1'b0;
          end
        end
        flash_guard_pkg::ST_PROG: begin
          if (op_timer == 20'h00000) begin
            op_state <= flash_guard_pkg::ST_IDLE;
          end else begin
            op_timer <= op_timer - 20'h00001;
          end
        end
        flash_guard_pkg::ST_ERASE: begin
          if (op_timer != 20'h00000) begin
            op_timer <= op_timer - 20'h00001;
          end
          if (!erase_done) begin
            erase_ptr <= erase_ptr + 14'h0001;
            erase_done <= (erase_ptr == erase_end);
          end
          if (erase_done && (op_timer == 20'h00000)) begin
            op_state <= flash_guard_pkg::ST_IDLE;
          end
        end
        default: begin
          op_state <= flash_guard_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Flash array
  // ----------------------------------------
  logic       mem_we;
  logic [13:0] mem_wa;
  logic [7:0] mem_wd;

  always_comb begin
    mem_we = 1'b0;
    mem_wa = xwr_addr[13:0];
    mem_wd = flash_mem[xwr_addr[13:0]] & xwr_data;
    if (op_state == flash_guard_pkg::ST_ERASE) begin
      mem_we = !erase_done;
      mem_wa = erase_ptr;
      mem_wd = `ERASED_BYTE;
    end else if (start_prog) begin
      mem_we = 1'b1;
      if (!xw_go) begin
        mem_wa = dbg_addr[13:0];
        mem_wd = flash_mem[dbg_addr[13:0]] & dbg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      flash_mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------
  // Lock byte sampled after reset
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_byte <= `LOCK_RESET;
    end else if (op_state == flash_guard_pkg::ST_SAMPLE) begin
      lock_byte <= flash_mem[`LOCK_ADDR];
    end
  end

  // ----------------------------------------
  // Read ports
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_data <= 8'h00;
      code_valid <= 1'b0;
    end else begin
      code_valid <= cr_take && !cr_bad;
      if (cr_take && !cr_bad) begin
        code_data <= flash_mem[code_addr[13:0]];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbg_rdata <= 8'h00;
      dbg_ack <= 1'b0;
      dbg_refused <= 1'b0;
    end else begin
      dbg_ack <= db_take;
      if (db_take) begin
        dbg_refused <= db_bad;
        if (!db_bad && (dbg_op == flash_guard_pkg::DBG_READ)) begin
          dbg_rdata <= flash_mem[dbg_addr[13:0]];
        end
      end
    end
  end

  // ----------------------------------------
  // Error reset
  // ----------------------------------------
  logic fw_error;
  logic flag_clear;

  assign fw_error = (xw_flash && xw_bad) ||
    (cr_take && cr_bad);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_error_reset <= 1'b0;
    end else begin
      flash_error_reset <= fw_error;
    end
  end

  // Flag survives the system reset it triggers
  always_ff @(posedge clk or posedge por_rst) begin
    if (por_rst) begin
      flash_error_reset_flag <= 1'b0;
    end else if (fw_error) begin
      flash_error_reset_flag <= 1'b1;
    end else if (flag_clear) begin
      flash_error_reset_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic apb_wr;
  logic mapped;

  assign mapped = (paddr == `OFF_CONTROL) ||
    (paddr == `OFF_KEY) || (paddr == `OFF_STATUS);
  assign apb_wr = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign flag_clear = apb_wr && (paddr == `OFF_STATUS) &&
    pwdata[`STS_FLAG_BIT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      store_write_enable <= 1'b0;
      store_erase_enable <= 1'b0;
    end else if (apb_wr && (paddr == `OFF_CONTROL)) begin
      store_write_enable <= pwdata[`CTL_WRITE_BIT];
      store_erase_enable <= pwdata[`CTL_ERASE_BIT];
    end
  end

  // ----------------------------------------
  // Unlock key
  // ----------------------------------------
  logic key_wr;
  logic [7:0] key_val;

  assign key_wr = apb_wr && (paddr == `OFF_KEY);
  assign key_val = pwdata[7:0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_state <= flash_guard_pkg::KEY_LOCKED;
      key_dead <= 1'b0;
    end else begin
      if (xw_flash && !xw_bad &&
          (key_state != flash_guard_pkg::KEY_OPEN)) begin
        key_dead <= 1'b1;
      end
      if (xw_go) begin
        key_state <= flash_guard_pkg::KEY_LOCKED;
      end else if (key_wr) begin
        case (key_state)
          flash_guard_pkg::KEY_LOCKED: begin
            if (key_val == `KEY_FIRST) begin
              key_state <= flash_guard_pkg::KEY_HALF;
            end else begin
              key_dead <= 1'b1;
            end
          end
          flash_guard_pkg::KEY_HALF: begin
            if (key_val == `KEY_SECOND) begin
              key_state <= flash_guard_pkg::KEY_OPEN;
            end else begin
              key_state <= flash_guard_pkg::KEY_LOCKED;
              key_dead <= 1'b1;
            end
          end
          default: begin
            key_state <= flash_guard_pkg::KEY_LOCKED;
            key_dead <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
      if (paddr == `OFF_CONTROL) begin
        prdata[`CTL_WRITE_BIT] <= store_write_enable;
        prdata[`CTL_ERASE_BIT] <= store_erase_enable;
      end
      if (paddr == `OFF_KEY) begin
        prdata[1:0] <= key_state;
      end
      if (paddr == `OFF_STATUS) begin
        prdata[`STS_BUSY_BIT] <= cpu_stall;
        prdata[`STS_DEAD_BIT] <= key_dead;
        prdata[`STS_KEY_LSB +: 2] <= key_state;
        prdata[`STS_FLAG_BIT] <= flash_error_reset_flag;
        prdata[`STS_LOCK_LSB +: 8] <= lock_byte;
      end
    end
  end

endmodule // flash_program_erase_guard

`default_nettype wire

// *** tb/flash_guard_chk.sv ***
// Purpose: Port assertions for flash_program_erase_guard
// Assumes: One clock domain on clk
// Notes:   Bound to every guard instance
`timescale 1ns/100ps
`default_nettype none
module flash_guard_chk #(
  parameter int unsigned ERASE_WAIT = 600
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic xwr_req,
  input wire logic xrd_req,
  input wire logic ram_wr_en,
  input wire logic ram_rd_en,
  input wire logic code_req,
  input wire logic code_valid,
  input wire logic dbg_req,
  input wire logic dbg_ack,
  input wire logic dbg_refused,
  input wire logic cpu_stall,
  input wire logic flash_error_reset,
  input wire logic flash_error_reset_flag
);
  // ------------------------------------------------------------
  // Stall length
  // ------------------------------------------------------------
  logic [15:0] stall_len;
  logic        len_ok;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_len <= 16'h0000;
    end else begin
      stall_len <= cpu_stall ? stall_len + 16'h0001 : 16'h0000;
    end
  end
  // Sample cycle, page erase, program or whole-array erase
  assign len_ok = (stall_len == 16'h0001) || (stall_len > 16'h4000) ||
                  (stall_len >= 16'(ERASE_WAIT) && stall_len <= 16'h03E9);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_ram_read_route: assert property (xrd_req |-> ram_rd_en)
    else $error("data read not sent to ram");
  a_ram_write_idle: assert property (ram_wr_en && !cpu_stall |=> !cpu_stall)
    else $error("ram write started a flash operation");
  a_stall_hold: assert property ($rose(cpu_stall) |-> cpu_stall [*8])
    else $error("stall dropped early");
  a_stall_time: assert property ($fell(cpu_stall) |-> len_ok)
    else $error("stall length wrong");
  a_dbg_quiet: assert property (dbg_ack && dbg_refused |-> !cpu_stall ##1 !cpu_stall)
    else $error("refused debug access started work");
  a_dbg_no_reset: assert property (dbg_req && !cpu_stall |=> !flash_error_reset)
    else $error("debug access caused reset");
  a_error_flag: assert property (flash_error_reset |=> flash_error_reset_flag)
    else $error("error reset without flag");
  a_code_answer: assert property (code_req && !cpu_stall && !xwr_req |=>
                                  code_valid != flash_error_reset)
    else $error("code read answer wrong");
endmodule // flash_guard_chk
bind flash_program_erase_guard flash_guard_chk #(.ERASE_WAIT(ERASE_WAIT)) flash_guard_chk_i (
  .clk, .sys_rst, .xwr_req, .xrd_req, .ram_wr_en, .ram_rd_en, .code_req, .code_valid,
  .dbg_req, .dbg_ack, .dbg_refused, .cpu_stall, .flash_error_reset, .flash_error_reset_flag);
`default_nettype wire

// *** tb/cpu_debug_model.sv ***
// Purpose: CPU core and debug port facing the flash guard
// Assumes: Requests taken at rising clk edges
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module cpu_debug_model (
  input  wire logic        clk,
  input  wire logic        cpu_stall,
  input  wire logic [7:0]  code_data,
  input  wire logic        code_valid,
  input  wire logic [7:0]  dbg_rdata,
  input  wire logic        dbg_ack,
  input  wire logic        dbg_refused,
  input  wire logic        flash_error_reset,
  output logic             xwr_req = 1'b0,
  output logic      [15:0] xwr_addr = 16'h0000,
  output logic      [7:0]  xwr_data = 8'h00,
  output logic             xrd_req = 1'b0,
  output logic      [15:0] fetch_pc = 16'h0000,
  output logic             code_req = 1'b0,
  output logic      [15:0] code_addr = 16'h0000,
  output logic             dbg_req = 1'b0,
  output logic      [1:0]  dbg_op = 2'h0,
  output logic      [15:0] dbg_addr = 16'h0000,
  output logic      [7:0]  dbg_wdata = 8'h00
);
  // ------------------------------------------------------------
  // Requests
  // ------------------------------------------------------------
  task automatic idle();
    repeat (2) @(posedge clk);
    while (cpu_stall !== 1'b0) begin
      @(posedge clk);
    end
  endtask
  // One byte per write
  task automatic xwrite(input logic [15:0] a, input logic [7:0] d, output logic e);
    @(posedge clk);
    xwr_req <= 1'b1;
    xrd_req <= 1'b1;
    xwr_addr <= a;
    xwr_data <= d;
    @(posedge clk);
    xwr_req <= 1'b0;
    xrd_req <= 1'b0;
    xwr_addr <= ~a;
    xwr_data <= ~d;
    @(posedge clk);
    e = flash_error_reset;
    idle();
  endtask
  task automatic code_rd(input logic [15:0] a, output logic [7:0] d, output logic v,
                         output logic e);
    @(posedge clk);
    code_req <= 1'b1;
    code_addr <= a;
    @(posedge clk);
    code_req <= 1'b0;
    code_addr <= ~a;
    @(posedge clk);
    d = code_data;
    v = code_valid;
    e = flash_error_reset;
  endtask
  task automatic dbg(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic f);
    @(posedge clk);
    dbg_req <= 1'b1;
    dbg_op <= op;
    dbg_addr <= a;
    dbg_wdata <= d;
    @(posedge clk);
    dbg_req <= 1'b0;
    dbg_addr <= ~a;
    dbg_wdata <= ~d;
    @(posedge clk);
    r = dbg_rdata;
    f = dbg_ack ? dbg_refused : 1'bx;
    idle();
  endtask
endmodule // cpu_debug_model
`default_nettype wire

// *** tb/flash_program_erase_guard_bench.sv ***
// Purpose: Self-checking bench for flash_program_erase_guard
// Assumes: APB master and partner model share clk
// Notes:   Flash contents mirrored in an associative array
`timescale 1ns/100ps
`default_nettype none
`include "flash_guard_params.svh"
module flash_program_erase_guard_bench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        por_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [15:0] xwr_addr, fetch_pc, code_addr, dbg_addr;
  logic [7:0]  xwr_data, code_data, dbg_wdata, dbg_rdata, lk;
  logic [1:0]  dbg_op, ctl;
  logic        pready, pslverr, xwr_req, xrd_req, ram_wr_en, ram_rd_en, code_req, code_valid;
  logic        dbg_req, dbg_ack, dbg_refused, cpu_stall, flash_error_reset;
  logic        flash_error_reset_flag, slv;
  logic [7:0]  mem [int];
  logic [31:0] seed = 32'hD1A95A77;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #20 clk = ~clk;
  flash_program_erase_guard #(.ERASE_WAIT(600)) flash_program_erase_guard_i (
    .clk, .sys_rst, .por_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .xwr_req, .xwr_addr, .xwr_data, .xrd_req, .ram_wr_en, .ram_rd_en, .fetch_pc,
    .code_req, .code_addr, .code_data, .code_valid, .dbg_req, .dbg_op, .dbg_addr, .dbg_wdata,
    .dbg_rdata, .dbg_ack, .dbg_refused, .cpu_stall, .flash_error_reset, .flash_error_reset_flag);
  cpu_debug_model cpu_debug_model_i (
    .clk, .cpu_stall, .code_data, .code_valid, .dbg_rdata, .dbg_ack, .dbg_refused,
    .flash_error_reset, .xwr_req, .xwr_addr, .xwr_data, .xrd_req, .fetch_pc, .code_req,
    .code_addr, .dbg_req, .dbg_op, .dbg_addr, .dbg_wdata);
  // ------------------------------------------------------------
  // Model and bus tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] rdm(input int a);
    return mem.exists(a) ? mem[a] : `ERASED_BYTE;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
    if (a == `OFF_CONTROL) ctl = d[1:0];
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [15:0] m,
                       input logic [15:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, r);
    chk(n, e, r[15:0] & m);
  endtask
  task automatic key();
    wr(`OFF_KEY, `KEY_FIRST);
    wr(`OFF_KEY, `KEY_SECOND);
  endtask
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    @(posedge clk);
    lk = rdm(`LOCK_ADDR);
  endtask
  // Outcome: 0 done, 1 error reset, 2 ignored
  task automatic fw(input logic [15:0] a, input logic [7:0] d, input int res);
    logic e;
    key();
    cpu_debug_model_i.xwrite(a, d, e);
    chk("fw_error", res == 1, e);
    if (res == 0 && ctl[1]) for (int i = 0; i < 512; i++) mem.delete({a[15:9], 9'h000} + i);
    else if (res == 0) mem[a] = rdm(a) & d;
  endtask
  task automatic cr(input logic [15:0] a, input int res);
    logic [7:0] d;
    logic v, e;
    cpu_debug_model_i.code_rd(a, d, v, e);
    chk("code_valid", res == 0, v);
    chk("code_error", res == 1, e);
    if (res == 0) chk("code_data", rdm(a), d);
  endtask
  task automatic dg(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
                    input logic f);
    logic [7:0] r;
    logic g;
    cpu_debug_model_i.dbg(op, a, d, r, g);
    chk("dbg_refused", f, g);
    if (!f && op == 2'h0) chk("dbg_rdata", rdm(a), r);
    if (!f && op == 2'h1) mem[a] = rdm(a) & d;
    if (!f && op == 2'h2) for (int i = 0; i < 512; i++) mem.delete({a[15:9], 9'h000} + i);
    if (!f && op == 2'h3) mem.delete();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    rst();
    dg(2'h3, 16'h0000, 8'h00, 1'b0);
    rst();
    cr(16'h0123, 0);
    rdchk("unmapped", 12'h00C, 16'hFFFF, 16'h0000);
    chk("pslverr", 1'b1, slv);
    $display("test device_erase done");
    wr(`OFF_CONTROL, 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      fw(16'h0123, seed[7:0], 0);
      cr(16'h0123, 0);
      rdchk("key_state", `OFF_KEY, 16'h0003, 16'h0000);
    end
    wr(`OFF_CONTROL, 32'h00000003);
    fw(16'h0155, 8'h00, 0);
    cr(16'h0123, 0);
    cr(16'h01FF, 0);
    rdchk("control", `OFF_CONTROL, 16'h0003, 16'h0003);
    $display("test program_erase done");
    wr(`OFF_CONTROL, 32'h00000000);
    wr(`OFF_KEY, `KEY_FIRST);
    cpu_debug_model_i.xwrite(16'h0040, 8'h00, slv);
    chk("ram_error", 1'b0, slv);
    rdchk("key_half", `OFF_KEY, 16'h0003, 16'h0001);
    rst();
    wr(`OFF_CONTROL, 32'h00000001);
    wr(`OFF_KEY, `KEY_FIRST);
    wr(`OFF_KEY, `KEY_SECOND);
    rdchk("key_open", `OFF_KEY, 16'h0003, 16'h0002);
    cpu_debug_model_i.xwrite(16'h0040, 8'h0F, slv);
    mem[16'h0040] = 8'h0F;
    cr(16'h0040, 0);
    $display("test redirect done");
    dg(2'h1, 16'h3E00, 8'h00, 1'b1);
    dg(2'h0, 16'h4000, 8'h00, 1'b1);
    wr(`OFF_CONTROL, 32'h00000003);
    fw(`LOCK_ADDR, 8'h00, 1);
    rst();
    rdchk("flag", `OFF_STATUS, 16'h0010, 16'h0010);
    $display("test refusals done");
    dg(2'h1, `LOCK_ADDR, 8'hFD, 1'b0);
    rdchk("lock_old", `OFF_STATUS, 16'hFF00, 16'hFF00);
    rst();
    rdchk("lock_new", `OFF_STATUS, 16'hFF00, {lk, 8'h00});
    cpu_debug_model_i.fetch_pc <= 16'h0400;
    cr(16'h0000, 1);
    rst();
    cr(16'h0400, 0);
    dg(2'h0, 16'h0200, 8'h00, 1'b1);
    dg(2'h0, 16'h0400, 8'h00, 1'b0);
    dg(2'h0, `LOCK_ADDR, 8'h00, 1'b1);
    cpu_debug_model_i.fetch_pc <= 16'h0000;
    cr(`LOCK_ADDR, 0);
    wr(`OFF_CONTROL, 32'h00000001);
    fw(16'h0010, 8'h3C, 0);
    cr(16'h0010, 0);
    dg(2'h2, 16'h3C00, 8'h00, 1'b1);
    dg(2'h3, 16'h0000, 8'h00, 1'b0);
    rst();
    rdchk("lock_clear", `OFF_STATUS, 16'hFF00, 16'hFF00);
    $display("test lock done");
    wr(`OFF_KEY, 32'h0000005A);
    rdchk("dead_key", `OFF_STATUS, 16'h0002, 16'h0002);
    wr(`OFF_CONTROL, 32'h00000001);
    fw(16'h0050, 8'h00, 2);
    cr(16'h0050, 0);
    rst();
    wr(`OFF_CONTROL, 32'h00000001);
    cpu_debug_model_i.xwrite(16'h0060, 8'h00, slv);
    chk("early_error", 1'b0, slv);
    fw(16'h0060, 8'h00, 2);
    rdchk("dead_early", `OFF_STATUS, 16'h0002, 16'h0002);
    cr(16'h0060, 0);
    $display("test key_faults done");
    results();
  end
endmodule // flash_program_erase_guard_bench
`default_nettype wire
